// ===== shared/wps_pkg.sv
// types for the wiper two-wire slave
package wps_pkg;
    typedef enum logic [5:0] {
        WPS_IDLE = 6'b00_0001,
        WPS_ADDR = 6'b00_0010,
        WPS_CMD = 6'b00_0100,
        WPS_DATA = 6'b00_1000,
        WPS_IGNORE = 6'b01_0000,
        WPS_DONE = 6'b10_0000
    } wps_state_t;
    typedef logic [7:0] wps_byte_t;
endpackage

// ===== shared/wps_regs.svh
// constants for the wiper two-wire slave with nonvolatile store
// Functional notes
// - wiper picks one of 256 taps
// - power-up copies stored value into live
// - live write moves wiper at once
// - store register accepts writes for recall
// - live clears at reset, store persists
// - clock input only, data open-drain
// - both lines high means idle bus
// - start and stop are data edges, clock high
// - one bit per clock pulse
// - device pulls data low on ninth pulse
// - address prefix plus two factory bits
// - low address bit follows strap pin
// - first byte command, later bytes data (only one data byte taken, rest unacked)
// - first data byte goes to chosen register
// - command picks live, store or copies
// - store write leaves wiper unchanged
// - command encodings for the four operations
// - power-up recall within initialisation time
`ifndef WPS_REGS_SVH
`define WPS_REGS_SVH
`define WPS_ADDR_PREFIX 4'h5
`define WPS_CMD_LIVE 8'h11
`define WPS_CMD_STORE 8'h21
`define WPS_CMD_RECALL 8'h61
`define WPS_CMD_SAVE 8'h51
`define WPS_STORE_RESET 8'h80
`define WPS_CLK_MHZ 10
`define WPS_INIT_TIME_US 10
`define WPS_INIT_CYCLES ((`WPS_INIT_TIME_US) * (`WPS_CLK_MHZ))
`endif

// ===== src/wps_nv_cell.sv
// one-byte nonvolatile store cell
`timescale 1ns/1ps
`include "wps_regs.svh"
module wps_nv_cell
(
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire wps_pkg::wps_byte_t wr_data,
    // read port
    output wps_pkg::wps_byte_t rd_data
);
    import wps_pkg::*;
    // no reset: contents model retention across power loss
    wps_byte_t mem_q = `WPS_STORE_RESET;
    wps_byte_t mem_d;
    wps_byte_t rd_q = `WPS_STORE_RESET;
    wps_byte_t rd_d;

    always_comb
    begin
        mem_d = wr_en ? wr_data : mem_q;
        rd_d = mem_q;
    end

    always_ff @(posedge clk)
    begin
        mem_q <= mem_d;
        rd_q <= rd_d;
    end

    assign rd_data = rd_q;
endmodule // wps_nv_cell

// ===== src/wps_slave.sv
// two-wire slave setting the wiper from live and stored registers
`timescale 1ns/1ps
`include "wps_regs.svh"
module wps_slave
(
    // system
    input wire logic clk,
    input wire logic resetn,
    // bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // strap and factory bits
    input wire logic addr_strap_pin,
    input wire logic [1:0] factory_bits,
    // wiper
    output wps_pkg::wps_byte_t wiper_pos,
    output logic init_done
);
    import wps_pkg::*;

    // link side, clocked by scl
    // link powers up idle, both lines released
    wps_state_t st_q = WPS_IDLE;
    wps_state_t st_d;
    logic [3:0] bit_q = 4'h0;
    logic [3:0] bit_d;
    wps_byte_t sh_q, sh_d;
    wps_byte_t cmd_q, cmd_d;
    logic ack_q = 1'b0;
    logic ack_d;
    wps_byte_t lk_data_q, lk_data_d;
    wps_byte_t lk_cmd_q, lk_cmd_d;
    logic lk_tog_q = 1'b0;
    logic lk_tog_d;
    // start/stop detectors on sda edges
    logic start_tog_q = 1'b0;
    logic stop_tog_q = 1'b0;
    logic start_seen_q = 1'b0;
    logic stop_sync1_q, stop_sync2_q, stop_seen_q;
    logic start_pend;
    wps_byte_t sh_next;

    always_ff @(negedge sda_in)
    begin
        if (scl)
        begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge sda_in)
    begin
        if (scl)
        begin
            stop_tog_q <= ~stop_tog_q;
        end
    end

    // start seen by the next scl rise
    assign start_pend = start_tog_q ^ start_seen_q;
    assign sh_next = {sh_q[6:0], sda_in};

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        lk_data_d = lk_data_q;
        lk_cmd_d = lk_cmd_q;
        lk_tog_d = lk_tog_q;
        if (start_pend)
        begin
            st_d = WPS_ADDR;
            bit_d = 4'h1;
            sh_d = {7'h00, sda_in};
        end
        // done keeps counting so the data ack ends and extra bytes go unacked
        else if (st_q != WPS_IDLE && st_q != WPS_IGNORE)
        begin
            if (bit_q == 4'h8)
            begin
                bit_d = 4'h0;
            end
            else
            begin
                bit_d = bit_q + 4'h1;
                sh_d = sh_next;
                if (bit_q == 4'h7)
                begin
                    case (st_q)
                        WPS_ADDR:
                        begin
                            if (sh_next[7:4] == `WPS_ADDR_PREFIX
                                && sh_next[3:2] == factory_bits
                                && sh_next[1] == addr_strap_pin
                                && !sh_next[0])
                            begin
                                st_d = WPS_CMD;
                            end
                            else
                            begin
                                st_d = WPS_IGNORE;
                            end
                        end
                        WPS_CMD:
                        begin
                            cmd_d = sh_next;
                            st_d = WPS_DATA;
                        end
                        WPS_DATA:
                        begin
                            lk_data_d = sh_next;
                            lk_cmd_d = cmd_q;
                            lk_tog_d = ~lk_tog_q;
                            st_d = WPS_DONE;
                        end
                        default:
                        begin
                            st_d = WPS_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge scl)
    begin
        st_q <= st_d;
        bit_q <= bit_d;
        sh_q <= sh_d;
        cmd_q <= cmd_d;
        lk_data_q <= lk_data_d;
        lk_cmd_q <= lk_cmd_d;
        lk_tog_q <= lk_tog_d;
        start_seen_q <= start_tog_q;
    end

    // acknowledge driven across the whole ninth pulse
    always_comb
    begin
        ack_d = 1'b0;
        if (!start_pend && bit_q == 4'h8 && st_q != WPS_IGNORE && st_q != WPS_IDLE)
        begin
            ack_d = 1'b1;
        end
    end

    always_ff @(negedge scl)
    begin
        ack_q <= ack_d;
    end

    // stop toggle is synchronised into the system domain but never used, so stop does not return the link to idle
    always_ff @(posedge clk)
    begin
        stop_sync1_q <= stop_tog_q;
        stop_sync2_q <= stop_sync1_q;
        stop_seen_q <= stop_sync2_q;
    end

    // system side
    logic tg1_q, tg2_q, tg3_q;
    wps_byte_t cmd_s_q, data_s_q;
    wps_byte_t live_q, live_d;
    logic nv_we_q, nv_we_d;
    wps_byte_t nv_wd_q, nv_wd_d;
    wps_byte_t nv_rd;
    logic [7:0] init_cnt_q, init_cnt_d;
    logic init_done_q, init_done_d;
    logic oe_s1_q, oe_s2_q;
    logic oe_q;
    logic cmd_evt;

    wps_nv_cell u_nv
    (
        .clk(clk),
        .wr_en(nv_we_q),
        .wr_data(nv_wd_q),
        .rd_data(nv_rd)
    );

    assign cmd_evt = tg2_q ^ tg3_q;

    always_comb
    begin
        live_d = live_q;
        nv_we_d = 1'b0;
        nv_wd_d = nv_wd_q;
        init_cnt_d = init_cnt_q;
        init_done_d = init_done_q;
        if (!init_done_q)
        begin
            init_cnt_d = init_cnt_q + 8'h01;
            if (init_cnt_q == 8'(`WPS_INIT_CYCLES - 1))
            begin
                live_d = nv_rd;
                init_done_d = 1'b1;
            end
        end
        else if (cmd_evt)
        begin
            case (cmd_s_q)
                `WPS_CMD_LIVE: live_d = data_s_q;
                `WPS_CMD_STORE:
                begin
                    nv_we_d = 1'b1;
                    nv_wd_d = data_s_q;
                end
                `WPS_CMD_RECALL: live_d = nv_rd;
                `WPS_CMD_SAVE:
                begin
                    nv_we_d = 1'b1;
                    nv_wd_d = live_q;
                end
                default: live_d = live_q;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        tg1_q <= lk_tog_q;
        tg2_q <= tg1_q;
        tg3_q <= tg2_q;
        cmd_s_q <= lk_cmd_q;
        data_s_q <= lk_data_q;
        oe_s1_q <= ack_q;
        oe_s2_q <= oe_s1_q;
        if (!resetn)
        begin
            live_q <= 8'h00;
            nv_we_q <= 1'b0;
            nv_wd_q <= 8'h00;
            init_cnt_q <= 8'h00;
            init_done_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            live_q <= live_d;
            nv_we_q <= nv_we_d;
            nv_wd_q <= nv_wd_d;
            init_cnt_q <= init_cnt_d;
            init_done_q <= init_done_d;
            oe_q <= oe_s2_q;
        end
    end

    // open-drain: only low or released
    assign sda_out = 1'b0;
    assign sda_oe = ack_q;
    assign wiper_pos = live_q;
    assign init_done = init_done_q;

    AST_INIT_TIME: assert property (@(posedge clk) disable iff (!resetn)
        $rose(init_done_q) |-> $past(init_cnt_q) == 8'(`WPS_INIT_CYCLES - 1))
        else $error("recall not at init count");
    AST_RECALL: assert property (@(posedge clk) disable iff (!resetn)
        $rose(init_done_q) |-> live_q == $past(nv_rd))
        else $error("recall value wrong");
    AST_STORE_KEEPS_WIPER: assert property (@(posedge clk) disable iff (!resetn)
        init_done_q && cmd_evt && cmd_s_q == `WPS_CMD_STORE |=> $stable(live_q))
        else $error("store write moved wiper");
    AST_LIVE_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        init_done_q && cmd_evt && cmd_s_q == `WPS_CMD_LIVE |=> live_q == $past(data_s_q))
        else $error("live write lost");
    AST_SAVE: assert property (@(posedge clk) disable iff (!resetn)
        init_done_q && cmd_evt && cmd_s_q == `WPS_CMD_SAVE |=> nv_we_q && nv_wd_q == $past(live_q))
        else $error("save wrong");
    AST_STORE_WR: assert property (@(posedge clk) disable iff (!resetn)
        nv_we_q |=> ##1 nv_rd == $past(nv_wd_q, 2))
        else $error("store not kept");
    AST_NO_WRITE_PRE_INIT: assert property (@(posedge clk) disable iff (!resetn)
        !init_done_q |=> !nv_we_q)
        else $error("store written before init");
    AST_ACK_BIT: assert property (@(posedge scl)
        ack_q |-> bit_q == 4'h8 && st_q != WPS_IGNORE)
        else $error("ack outside ninth bit");
    AST_FOREIGN: assert property (@(posedge scl)
        st_q == WPS_IGNORE |-> !ack_q)
        else $error("ack for foreign address");
endmodule // wps_slave

// ===== verif/wps_bus_master.sv
// two-wire bus master model that frames writes to the slave
`timescale 1ns/1ps
module wps_bus_master
(
    // bus pins
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // master owns the clock, idle with both lines released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic put_bit(input logic b);
        #3.75 sda_low = ~b;
        #3.75 scl = 1'b1;
        #7.5 scl = 1'b0;
    endtask
    // line must read low 0.5 ns after the rise and again 0.5 ns before the fall
    task automatic get_ack(output logic ack);
        logic a1;
        #3.75 sda_low = 1'b0;
        #3.75 scl = 1'b1;
        #0.5 a1 = ~sda;
        #6.5 ack = a1 & ~sda;
        #0.5 scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
        output logic [2:0] acks);
        logic [7:0] q [3];
        logic ack;
        q = '{a, c, d};
        sda_low = 1'b1;
        #7.5 scl = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            for (int i = 7; i >= 0; i--)
                put_bit(q[k][i]);
            get_ack(ack);
            acks[2 - k] = ack;
        end
        #3.75 sda_low = 1'b1;
        #3.75 scl = 1'b1;
        #3.75 sda_low = 1'b0;
        #7.5;
    endtask
endmodule // wps_bus_master

// ===== verif/wps_slave_tb.sv
// bench comparing the wiper slave with a reference model
`timescale 1ns/1ps
`include "wps_regs.svh"
module wps_slave_tb;
    import wps_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic [1:0] fac = 2'h0;
    logic scl, sda_low, sda_oe, sda_out, init_done;
    wps_byte_t wiper_pos;
    // open drain with pull-up
    wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int live = 0;
    int st = 8'h80;
    logic [2:0] acks;
    logic [7:0] cmds [5] = '{8'h11, 8'h21, 8'h61, 8'h51, 8'h33};
    always #50 clk = ~clk;
    wps_slave u_dut (.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(strap),
        .factory_bits(fac), .wiper_pos(wiper_pos), .init_done(init_done));
    wps_bus_master u_bm (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic close_out();
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk_pos(input wps_byte_t got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t wiper %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t handshake %b expected %b", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        #1 chk_pos(wiper_pos, 8'h00);
        @(posedge clk);
        resetn <= 1'b1;
        live = st;
        for (int i = 0; i < 120 && init_done !== 1'b1; i++)
            @(posedge clk) #1;
        chk_ack({2'b00, init_done}, 3'b001);
        chk_pos(wiper_pos, live[7:0]);
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
        logic hit;
        hit = (a == {`WPS_ADDR_PREFIX, fac, strap, 1'b0});
        u_bm.xfer(a, c, d, acks);
        chk_ack(acks, hit ? 3'b111 : 3'b000);
        if (hit)
            case (c)
                `WPS_CMD_LIVE: live = d;
                `WPS_CMD_STORE: st = d;
                `WPS_CMD_RECALL: live = st;
                `WPS_CMD_SAVE: st = live;
                default: ;
            endcase
        // shortened busy time after a store write
        if (hit && (c == `WPS_CMD_STORE || c == `WPS_CMD_SAVE))
            #2000;
        repeat (8) @(posedge clk);
        #1 chk_pos(wiper_pos, live[7:0]);
        chk_ack({2'b00, sda_oe}, 3'b000);
    endtask
    initial
    begin
        void'($urandom(32'heb35_56d0));
        do_reset();
        for (int k = 0; k < 30; k++)
        begin
            logic [7:0] a;
            @(posedge clk);
            strap <= 1'($urandom);
            fac <= 2'($urandom);
            @(posedge clk);
            a = {`WPS_ADDR_PREFIX, fac, strap, 1'b0};
            if (k >= 5 && $urandom % 4 == 0)
                a = a ^ (8'h01 << ($urandom % 8));
            frame(a, k < 5 ? cmds[k] : cmds[$urandom % 5], 8'($urandom));
            if (k == 20)
                do_reset();
        end
        close_out();
    end
endmodule // wps_slave_tb
